// ===== inc/tpa_pkg.sv
package tpa_pkg;
  // Channel count and widths
  localparam int unsigned NCH = 4;
  localparam int unsigned CAP_W = 16;
  localparam int unsigned ACC_W = 8;
  localparam int unsigned DLY_W = 8;

  // Register byte addresses
  localparam logic [7:0] ADDR_EDGE = 8'h00;
  localparam logic [7:0] ADDR_CTRL = 8'h04;
  localparam logic [7:0] ADDR_CMP = 8'h08;
  localparam logic [7:0] ADDR_FORCE = 8'h0c;
  localparam logic [7:0] ADDR_DELAY = 8'h10;
  localparam logic [7:0] ADDR_ACC = 8'h14;
  localparam logic [7:0] ADDR_HOLD = 8'h18;
  localparam logic [7:0] ADDR_CAP0 = 8'h20;
  localparam logic [7:0] ADDR_CAP3 = 8'h2c;

  // Control register bit positions
  localparam int unsigned CTRL_TEN = 0;
  localparam int unsigned CTRL_SAT = 1;
  localparam int unsigned CTRL_QUEUE = 2;
  localparam int unsigned CTRL_WIDE_LO = 3;
  localparam int unsigned CTRL_WIDE_HI = 4;
  localparam int unsigned CTRL_LATCH = 5;
  localparam int unsigned CTRL_W = 5;

  // Reset values
  localparam logic [7:0] EDGE_RST = 8'h00;
  localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;
  localparam logic [DLY_W-1:0] DELAY_RST = 8'h00;
  localparam logic [15:0] CMP_RST = 16'h0000;
  localparam logic [ACC_W-1:0] ACC_MAX = 8'hff;

  // Edge select encodings
  localparam logic [1:0] EDGE_OFF = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_ANY = 2'h3;

  // Compare output actions as {mode, level}
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_CLEAR = 2'h2;
  localparam logic [1:0] ACT_SET = 2'h3;

  // Compare configuration register layout
  typedef struct packed {
    logic [3:0] level;
    logic [3:0] mode;
    logic [3:0] disc;
    logic [3:0] sel;
  } tpa_cmp_cfg_t;
endpackage

// ===== hw/tpa_top.sv
`timescale 1ns/10ps
// Behaviour
// - Pulses between delay-1 and delay cycles may pass or be dropped.
// - Pulses lasting at least the delay count are always accepted.
// - Disconnect bit set keeps compare output off the pin.
// - Disconnect bits reset to zero so compare drives once enabled.
// - Force bit performs a compare action on the internal output state.
// - Clearing disconnect hands pin to compare logic with its held state.
// - Four 8-bit accumulators with 8-bit holding registers on channels 3..0.
// - Each accumulator increments once per active edge on its channel.
// - Saturation bit stops 8-bit accumulators at 0xff.
// - Each accumulator pair can work as one 16-bit accumulator.
// - Second wide accumulator counts channel 2 events, edges from select bits 5:4.
// - Latch mode copies to holding and clears on latch events.
// - Queue mode copies accumulator to holding on capture register read.
// - Edge select register holds two bits per channel, always accessible.
// - Edge select register resets to zero.
module tpa_top #(
  parameter int unsigned DLY_W = tpa_pkg::DLY_W
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] timer_in,
  input wire logic mdc_zero,
  input wire logic mdc_load_zero,
  output logic [3:0] oc_pin_o,
  output logic [3:0] oc_pin_oe_n
);
  localparam int unsigned NCH = tpa_pkg::NCH;

  logic [1:0] rst_sync_q;
  logic rst_n;
  logic [7:0] edge_q;
  logic [tpa_pkg::CTRL_W-1:0] ctrl_q;
  tpa_pkg::tpa_cmp_cfg_t cmp_q;
  logic [DLY_W-1:0] dly_q;
  logic [tpa_pkg::CAP_W-1:0] tcnt_q;
  logic [tpa_pkg::CAP_W-1:0] cap_q [NCH];
  logic [tpa_pkg::ACC_W-1:0] acc_q [NCH];
  logic [tpa_pkg::ACC_W-1:0] hold_q [NCH];
  logic [DLY_W-1:0] flt_cnt_q [NCH];
  logic [NCH-1:0] filt_q, filt_p_q, state_q, hit, inc, carry, qread, force_cmp, drive;
  logic [31:0] prdata_q, rdata, wmask, wnew;
  logic pready_q, pslverr_q, access, done, wr, unmapped, latch_ev, timer_enable_bit, queue;
  logic [1:0] wide;

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // Bus phases: one wait state so read data can come from a flop
  assign access = psel & penable;
  assign done = access & pready_q;
  assign wr = done & pwrite & ~pslverr_q;
  assign wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
  assign timer_enable_bit = ctrl_q[tpa_pkg::CTRL_TEN];
  assign queue = ctrl_q[tpa_pkg::CTRL_QUEUE];
  assign wide = {ctrl_q[tpa_pkg::CTRL_WIDE_HI], ctrl_q[tpa_pkg::CTRL_WIDE_LO]};

  // Written lanes over the current value; the read mux already selects it
  assign wnew = (rdata & ~wmask) | (pwdata & wmask);

  // Address decode and read mux
  always_comb begin
    rdata = 32'h0000_0000;
    unmapped = 1'b0;
    case (paddr)
      tpa_pkg::ADDR_EDGE: rdata = {24'h00_0000, edge_q};
      tpa_pkg::ADDR_CTRL: rdata = {27'h000_0000, ctrl_q};
      tpa_pkg::ADDR_CMP: rdata = {16'h0000, cmp_q};
      tpa_pkg::ADDR_FORCE: rdata = {24'h00_0000, state_q, 4'h0};
      tpa_pkg::ADDR_DELAY: rdata = 32'(dly_q);
      tpa_pkg::ADDR_ACC: rdata = {acc_q[3], acc_q[2], acc_q[1], acc_q[0]};
      tpa_pkg::ADDR_HOLD: rdata = {hold_q[3], hold_q[2], hold_q[1], hold_q[0]};
      default: begin
        if (paddr >= tpa_pkg::ADDR_CAP0 && paddr <= tpa_pkg::ADDR_CAP3 && paddr[1:0] == 2'h0) begin
          rdata = {16'h0000, cap_q[paddr[3:2]]};
        end else begin
          unmapped = 1'b1;
        end
      end
    endcase
  end

  // Answer flops: data and error settle during the wait state
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= access & ~pready_q;
      if (access && !pready_q) begin
        prdata_q <= pwrite ? 32'h0000_0000 : rdata;
        pslverr_q <= unmapped;
      end else if (!access) begin
        pslverr_q <= 1'b0;
      end
    end
  end
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  // Software registers; edge select writable any time
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      edge_q <= tpa_pkg::EDGE_RST;
      ctrl_q <= tpa_pkg::CTRL_RST;
      cmp_q <= tpa_pkg::CMP_RST;
      dly_q <= DLY_W'(tpa_pkg::DELAY_RST);
    end else if (wr) begin
      case (paddr)
        tpa_pkg::ADDR_EDGE: edge_q <= wnew[7:0];
        tpa_pkg::ADDR_CTRL: ctrl_q <= wnew[tpa_pkg::CTRL_W-1:0];
        tpa_pkg::ADDR_CMP: cmp_q <= wnew[15:0];
        tpa_pkg::ADDR_DELAY: dly_q <= wnew[DLY_W-1:0];
        default: ;
      endcase
    end
  end

  // Latch bit is a strobe, never stored; counter events join it
  assign latch_ev = mdc_zero | mdc_load_zero |
    (wr && paddr == tpa_pkg::ADDR_CTRL && pstrb[0] && pwdata[tpa_pkg::CTRL_LATCH]);

  // Free-running timebase for capture and compare
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tcnt_q <= 16'h0000;
    end else if (timer_enable_bit) begin
      tcnt_q <= tcnt_q + 16'h0001;
    end
  end

  genvar i;
  for (i = 0; i < NCH; i++) begin : g_ch
    logic [1:0] esel, act;
    logic rise, fall;
    assign esel = edge_q[2*i+1:2*i];
    assign rise = filt_q[i] & ~filt_p_q[i];
    assign fall = ~filt_q[i] & filt_p_q[i];
    // Active edge decode per select code
    always_comb begin
      case (esel)
        tpa_pkg::EDGE_RISE: hit[i] = rise;
        tpa_pkg::EDGE_FALL: hit[i] = fall;
        tpa_pkg::EDGE_ANY: hit[i] = rise | fall;
        default: hit[i] = 1'b0;
      endcase
    end

    // Delay filter: a level must persist for the full count to pass
    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        flt_cnt_q[i] <= '0;
        filt_q[i] <= 1'b0;
        filt_p_q[i] <= 1'b0;
      end else begin
        filt_p_q[i] <= filt_q[i];
        if (timer_in[i] == filt_q[i]) begin
          flt_cnt_q[i] <= '0;
        end else if (flt_cnt_q[i] + 1'b1 >= dly_q || dly_q == '0) begin
          filt_q[i] <= timer_in[i];
          flt_cnt_q[i] <= '0;
        end else begin
          flt_cnt_q[i] <= flt_cnt_q[i] + 1'b1;
        end
      end
    end

    // Upper half of a wide pair counts lower overflow only
    if (i % 2 == 1) begin : g_hi
      assign inc[i] = wide[i/2] ? carry[i-1] : hit[i];
    end else begin : g_lo
      assign inc[i] = hit[i];
    end
    assign carry[i] = inc[i] & (acc_q[i] == tpa_pkg::ACC_MAX);
    assign qread[i] = done & ~pwrite & (paddr == tpa_pkg::ADDR_CAP0 + 8'(4 * i));

    // Accumulator and holding register; latch clear outranks a same-cycle edge
    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        acc_q[i] <= '0;
        hold_q[i] <= '0;
      end else if (latch_ev && !queue) begin
        hold_q[i] <= acc_q[i];
        acc_q[i] <= '0;
      end else begin
        if (queue && qread[i]) begin
          hold_q[i] <= acc_q[i];
        end
        if (inc[i] && !(ctrl_q[tpa_pkg::CTRL_SAT] && !wide[i/2] && carry[i])) begin
          acc_q[i] <= acc_q[i] + 1'b1;
        end
      end
    end

    // Capture on input channels, compare value written by software
    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        cap_q[i] <= '0;
      end else if (wr && paddr == tpa_pkg::ADDR_CAP0 + 8'(4 * i)) begin
        cap_q[i] <= wnew[15:0];
      end else if (!cmp_q.sel[i] && timer_enable_bit && hit[i]) begin
        cap_q[i] <= tcnt_q;
      end
    end

    // Compare action, also run by a force write regardless of pin state
    assign act = {cmp_q.mode[i], cmp_q.level[i]};
    assign force_cmp[i] = wr && paddr == tpa_pkg::ADDR_FORCE && pstrb[0] && pwdata[i];
    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        state_q[i] <= 1'b0;
      end else if (cmp_q.sel[i] && timer_enable_bit && (force_cmp[i] || tcnt_q == cap_q[i])) begin
        case (act)
          tpa_pkg::ACT_TOGGLE: state_q[i] <= ~state_q[i];
          tpa_pkg::ACT_CLEAR: state_q[i] <= 1'b0;
          tpa_pkg::ACT_SET: state_q[i] <= 1'b1;
          default: state_q[i] <= state_q[i];
        endcase
      end
    end

    // Pin hand-over; the port logic outside drives while we release
    assign drive[i] = cmp_q.sel[i] & timer_enable_bit & ~cmp_q.disc[i];
    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        oc_pin_o[i] <= 1'b0;
        oc_pin_oe_n[i] <= 1'b1;
      end else begin
        oc_pin_o[i] <= drive[i] & state_q[i];
        oc_pin_oe_n[i] <= ~drive[i];
      end
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_handover;
    cmp_q.sel[0] && timer_enable_bit && $fell(cmp_q.disc[0]);
  endsequence

  a_disc_pin_off: assert property (cmp_q.disc[0] |=> oc_pin_oe_n[0])
    else $error("pin driven while disconnected");
  a_disc_reset_zero: assert property ($rose(rst_n) |-> cmp_q.disc == 4'h0)
    else $error("disconnect bits not zero after reset");
  a_force_set_state: assert property (force_cmp[0] && cmp_q.sel[0] && timer_enable_bit &&
    cmp_q.mode[0] && cmp_q.level[0] |=> state_q[0])
    else $error("force did not set state");
  a_pin_handover: assert property (s_handover |=> !oc_pin_oe_n[0] &&
    oc_pin_o[0] == $past(state_q[0]))
    else $error("pin not handed to compare state");
  a_edge_counts: assert property (inc[0] && !latch_ev && acc_q[0] != 8'hff
    |=> acc_q[0] == $past(acc_q[0]) + 8'h01)
    else $error("edge not counted");
  a_sat_holds: assert property (ctrl_q[1] && !wide[1] && acc_q[2] == 8'hff && !latch_ev
    |=> acc_q[2] == 8'hff)
    else $error("saturated accumulator wrapped");
  a_wide_carry: assert property (wide[0] && carry[0] && !latch_ev
    |=> acc_q[1] == $past(acc_q[1]) + 8'h01 && acc_q[0] == 8'h00)
    else $error("wide carry lost");
  a_latch_copy: assert property (latch_ev && !queue
    |=> hold_q[2] == $past(acc_q[2]) && acc_q[2] == 8'h00)
    else $error("latch did not copy and clear");
  a_queue_copy: assert property (queue && qread[3] && !latch_ev
    |=> hold_q[3] == $past(acc_q[3]))
    else $error("queue read did not copy");
  a_filter_accept: assert property (dly_q != '0 && timer_in[1] != filt_q[1] &&
    flt_cnt_q[1] + 1'b1 >= dly_q |=> filt_q[1] == $past(timer_in[1]))
    else $error("long pulse rejected");
  a_edge_reset: assert property ($rose(rst_n) |-> edge_q == 8'h00)
    else $error("edge select not cleared");
endmodule

// ===== sim/tpa_partner.sv
`timescale 1ns/10ps
module tpa_partner (
  input wire logic ref_clk,
  input wire logic [3:0] oc_pin_o,
  input wire logic [3:0] oc_pin_oe_n,
  output logic [3:0] timer_in,
  output logic [3:0] pin_lvl
);
  // Pin level: weak pull-down wins whenever the block lets go
  assign pin_lvl = oc_pin_o & ~oc_pin_oe_n;

  initial timer_in = 4'h0;

  // Pulse train, each phase at least three clocks so no edge is lost
  task automatic burst(input int ch, input int n, input int w);
    repeat (n) begin
      timer_in[ch] <= 1'b1;
      repeat (w) @(posedge ref_clk);
      timer_in[ch] <= 1'b0;
      repeat (w) @(posedge ref_clk);
    end
  endtask
endmodule

// ===== sim/timer_pulse_accumulator_oc_init_test.sv
`timescale 1ns/10ps
module timer_pulse_accumulator_oc_init_test;
  logic ref_clk, rstn, psel, penable, pwrite, mdc_zero, mdc_load_zero, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, seed;
  logic [3:0] pstrb, timer_in, oc_pin_o, oc_pin_oe_n, pin_lvl;
  int fail_count, check_count, ctrl;
  int acc_m[4], hold_m[4];

  tpa_top uut (.ref_clk(ref_clk), .rstn(rstn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .timer_in(timer_in), .mdc_zero(mdc_zero),
    .mdc_load_zero(mdc_load_zero), .oc_pin_o(oc_pin_o), .oc_pin_oe_n(oc_pin_oe_n));
  tpa_partner far (.ref_clk(ref_clk), .oc_pin_o(oc_pin_o), .oc_pin_oe_n(oc_pin_oe_n),
    .timer_in(timer_in), .pin_lvl(pin_lvl));

  // Clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task end_of_test;
    if (fail_count == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task chk_word(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t: word %h expected %h", $time, got, exp);
    end
  endtask

  task chk_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t: pin %b expected %b", $time, got, exp);
    end
  endtask

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // One APB transfer; the leading edge keeps psel low between transfers
  task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    // No cycle budget here: only the watchdog may end a hung transfer
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task set_ctrl(input int v);
    ctrl = v;
    apb(tpa_pkg::ADDR_CTRL, 1'b1, v);
  endtask

  // Model: wide pair carries into the upper byte, saturation only in 8-bit mode
  task add(input int ch, input int k);
    int v;
    if (ch % 2 == 0 && ctrl[3 + ch / 2]) begin
      v = acc_m[ch] + 256 * acc_m[ch + 1] + k;
      acc_m[ch] = v % 256;
      acc_m[ch + 1] = (v / 256) % 256;
    end else if (ctrl[1]) acc_m[ch] = (acc_m[ch] + k > 255) ? 255 : acc_m[ch] + k;
    else acc_m[ch] = (acc_m[ch] + k) % 256;
  endtask

  task pulses(input int ch, input int n, input int w, input int per);
    far.burst(ch, n, w);
    add(ch, n * per);
    repeat (12) @(posedge ref_clk);
  endtask

  task chk_arr(input logic [7:0] a, input int m[4]);
    apb(a, 1'b0, 32'h0);
    chk_word(rd, {m[3][7:0], m[2][7:0], m[1][7:0], m[0][7:0]});
  endtask

  // Three latch sources, all clearing every accumulator into its holding copy
  task latch(input int src);
    if (src == 2) apb(tpa_pkg::ADDR_CTRL, 1'b1, ctrl | 32'h20);
    else begin
      if (src == 0) mdc_zero <= 1'b1;
      else mdc_load_zero <= 1'b1;
      @(posedge ref_clk);
      mdc_zero <= 1'b0;
      mdc_load_zero <= 1'b0;
    end
    repeat (3) @(posedge ref_clk);
    foreach (acc_m[i]) begin
      hold_m[i] = acc_m[i];
      acc_m[i] = 0;
    end
  endtask

  // Main sequence
  initial begin
    rstn = 1'b0;
    {psel, penable, pwrite, mdc_zero, mdc_load_zero} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'hf;
    seed = 32'd80822;
    {ctrl, fail_count, check_count} = 0;
    foreach (acc_m[i]) {acc_m[i], hold_m[i]} = 0;
    repeat (12) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk_word({28'h0, oc_pin_oe_n}, 32'hf);
    apb(tpa_pkg::ADDR_EDGE, 1'b0, 32'h0);
    chk_word(rd, 32'h0);
    apb(tpa_pkg::ADDR_CMP, 1'b0, 32'h0);
    chk_word(rd, 32'h0);
    seed = lfsr(seed);
    apb(tpa_pkg::ADDR_EDGE, 1'b1, {24'h0, seed[7:0]});
    apb(tpa_pkg::ADDR_EDGE, 1'b0, 32'h0);
    chk_word(rd, {24'h0, seed[7:0]});
    apb(8'h1c, 1'b0, 32'h0);
    chk_word({rd[30:0], err}, 32'h1);
    apb(8'h02, 1'b1, 32'hff);
    chk_word({rd[30:0], err}, 32'h1);
    // Every edge code on all channels, random pulse counts
    for (int c = 0; c < 4; c++) begin
      apb(tpa_pkg::ADDR_EDGE, 1'b1, {24'h0, {4{c[1:0]}}});
      for (int ch = 0; ch < 4; ch++) begin
        seed = lfsr(seed);
        pulses(ch, 1 + seed[2:0], 3, (c == 3) ? 2 : ((c == 0) ? 0 : 1));
      end
      chk_arr(tpa_pkg::ADDR_ACC, acc_m);
      latch(c % 3);
      chk_arr(tpa_pkg::ADDR_ACC, acc_m);
      chk_arr(tpa_pkg::ADDR_HOLD, hold_m);
    end
    // Filter: pulses exactly as long as the delay count
    apb(tpa_pkg::ADDR_DELAY, 1'b1, 32'h4);
    pulses(1, 3, 4, 2);
    chk_arr(tpa_pkg::ADDR_ACC, acc_m);
    apb(tpa_pkg::ADDR_DELAY, 1'b1, 32'h0);
    set_ctrl(2);
    pulses(2, 130, 3, 2);
    chk_arr(tpa_pkg::ADDR_ACC, acc_m);
    latch(0);
    apb(tpa_pkg::ADDR_CMP, 1'b1, 32'h1);
    set_ctrl(8);
    pulses(0, 129, 3, 2);
    chk_arr(tpa_pkg::ADDR_ACC, acc_m);
    set_ctrl(16);
    pulses(2, 129, 3, 2);
    chk_arr(tpa_pkg::ADDR_ACC, acc_m);
    set_ctrl(4);
    pulses(3, 2, 3, 2);
    apb(tpa_pkg::ADDR_CAP3, 1'b0, 32'h0);
    hold_m[3] = acc_m[3];
    chk_arr(tpa_pkg::ADDR_HOLD, hold_m);
    // Pin hand-over: preset the state while disconnected, then release
    apb(tpa_pkg::ADDR_CAP0, 1'b1, 32'hffff);
    set_ctrl(5);
    apb(tpa_pkg::ADDR_CMP, 1'b1, 32'h1111);
    apb(tpa_pkg::ADDR_FORCE, 1'b1, 32'h1);
    apb(tpa_pkg::ADDR_FORCE, 1'b0, 32'h0);
    chk_word(rd & 32'h10, 32'h10);
    chk_bit(oc_pin_oe_n[0], 1'b1);
    apb(tpa_pkg::ADDR_CMP, 1'b1, 32'h1101);
    repeat (2) @(posedge ref_clk);
    chk_bit(oc_pin_oe_n[0], 1'b0);
    chk_bit(pin_lvl[0], 1'b1);
    // Toggle action forced while connected: pin follows one cycle later
    apb(tpa_pkg::ADDR_CMP, 1'b1, 32'h1001);
    apb(tpa_pkg::ADDR_FORCE, 1'b1, 32'h1);
    repeat (2) @(posedge ref_clk);
    chk_bit(pin_lvl[0], 1'b0);
    end_of_test;
  end

  // Watchdog, well past the few thousand cycles the run needs
  initial begin
    repeat (20000) @(posedge ref_clk);
    fail_count++;
    $display("ERROR %0t: timeout", $time);
    end_of_test;
  end
endmodule
